/* File: hw/jcp_pkg.sv */
`default_nettype none
package jcp_pkg;
  // Opcode prefixes
  localparam logic [7:0] PFX_NONE = 8'h00;
  localparam logic [7:0] PFX_EXT = 8'hed;
  localparam logic [7:0] PFX_IDX1 = 8'hdd;
  localparam logic [7:0] PFX_IDX2 = 8'hfd;
  // Control-flow opcodes
  localparam logic [7:0] OP_JP_IND = 8'he9;
  localparam logic [7:0] OP_CALL = 8'hcd;
  localparam logic [7:0] OP_RET = 8'hc9;
  localparam logic [7:0] OP_RET_MI = 8'h4d;
  localparam logic [7:0] OP_RET_NMI = 8'h45;
  localparam logic [7:0] OP_LOOP = 8'h10;
  localparam logic [7:0] RST_MASK = 8'hc7;
  localparam logic [7:0] RST_MATCH = 8'hc7;
  // Port opcodes
  localparam logic [7:0] OP_IN_IMM = 8'hdb;
  localparam logic [7:0] OP_OUT_IMM = 8'hd3;
  localparam logic [7:0] RSEL_MASK = 8'hc7;
  localparam logic [7:0] IN_REG_MATCH = 8'h40;
  localparam logic [7:0] OUT_REG_MATCH = 8'h41;
  localparam logic [7:0] BLK_MASK = 8'he6;
  localparam logic [7:0] BLK_MATCH = 8'ha2;
  // Field positions inside the opcode
  localparam int BLK_OUT_BIT = 0;
  localparam int BLK_DOWN_BIT = 3;
  localparam int BLK_RPT_BIT = 4;
  localparam int RSEL_LSB = 3;
  localparam int RSEL_MSB = 5;
  // Register file indices
  localparam logic [2:0] R_B = 3'h0;
  localparam logic [2:0] R_C = 3'h1;
  localparam logic [2:0] R_H = 3'h4;
  localparam logic [2:0] R_L = 3'h5;
  localparam logic [2:0] R_A = 3'h7;
  localparam int NUM_REGS = 8;
  // Load port selects above the 8-bit registers
  localparam logic [3:0] LD_SP = 4'h8;
  localparam logic [3:0] LD_IX = 4'h9;
  localparam logic [3:0] LD_IY = 4'ha;
  // Counts and reset values
  localparam logic [8:0] BLK_FULL = 9'h100;
  localparam logic [8:0] BLK_ONE = 9'h001;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam int BUF_DEPTH_DEF = 2;
  typedef enum logic [2:0] {
    S_IDLE, S_PUSH_HI, S_PUSH_LO, S_POP_LO, S_POP_HI, S_IO, S_BLK
  } jcp_state_e;
endpackage : jcp_pkg
`default_nettype wire

/* File: hw/jcp_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module jcp_exec import jcp_pkg::*; #(
  parameter int BUF_DEPTH = BUF_DEPTH_DEF
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_OP_VALID,
  input wire logic [7:0] I_OP_PREFIX,
  input wire logic [7:0] I_OP_CODE,
  input wire logic [15:0] I_OP_IMM,
  input wire logic [15:0] I_OP_PC_NEXT,
  output logic O_OP_READY,
  output logic O_DONE,
  output logic O_RETURN_FROM_MASKABLE_IRQ,
  input wire logic I_REG_WE,
  input wire logic [3:0] I_REG_SEL,
  input wire logic [15:0] I_REG_DATA,
  output logic [15:0] O_PC,
  output logic [15:0] O_SP,
  output logic [7:0] O_B,
  output logic [15:0] O_HL,
  output logic O_MEM_REQ,
  output logic O_MEM_WR,
  output logic [15:0] O_MEM_ADDR,
  output logic [7:0] O_MEM_WDATA,
  input wire logic I_MEM_ACK,
  input wire logic [7:0] I_MEM_RDATA,
  output logic O_IO_REQ,
  output logic O_IO_WR,
  output logic [15:0] O_IO_ADDR,
  output logic [7:0] O_IO_WDATA,
  input wire logic I_IO_ACK,
  input wire logic [7:0] I_IO_RDATA
);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);

  jcp_state_e state;
  logic [7:0] regs [0:NUM_REGS-1];
  logic [15:0] sp, ix, iy, pc, tgt, lat_next;
  logic [2:0] io_dst;
  logic blk_out, blk_down, rd_busy, wr_busy;
  logic [8:0] rd_left;
  logic [7:0] buf_mem [0:BUF_DEPTH-1];
  logic [PW-1:0] wp, rp;
  logic [CW-1:0] cnt;

  ////////////////////////////////////////////////////////////////////////
  // Opcode decode
  wire take = I_OP_VALID & O_OP_READY;
  wire pfx_none = (I_OP_PREFIX == PFX_NONE);
  wire pfx_ext = (I_OP_PREFIX == PFX_EXT);
  wire [15:0] hl = {regs[R_H], regs[R_L]};
  wire [15:0] bc = {regs[R_B], regs[R_C]};
  wire is_jp = (I_OP_CODE == OP_JP_IND) & ~pfx_ext;
  wire is_call = pfx_none & (I_OP_CODE == OP_CALL);
  wire is_rst = pfx_none & ((I_OP_CODE & RST_MASK) == RST_MATCH);
  wire is_return_from_maskable_irq = pfx_ext & (I_OP_CODE == OP_RET_MI);
  wire is_ret = (pfx_none & (I_OP_CODE == OP_RET)) | is_return_from_maskable_irq |
                (pfx_ext & (I_OP_CODE == OP_RET_NMI));
  wire is_loop = pfx_none & (I_OP_CODE == OP_LOOP);
  wire is_in_imm = pfx_none & (I_OP_CODE == OP_IN_IMM);
  wire is_out_imm = pfx_none & (I_OP_CODE == OP_OUT_IMM);
  wire is_in_reg = pfx_ext & ((I_OP_CODE & RSEL_MASK) == IN_REG_MATCH);
  wire is_out_reg = pfx_ext & ((I_OP_CODE & RSEL_MASK) == OUT_REG_MATCH);
  wire is_blk = pfx_ext & ((I_OP_CODE & BLK_MASK) == BLK_MATCH);
  wire [2:0] rsel = I_OP_CODE[RSEL_MSB:RSEL_LSB];

  // Target selection for jumps, restarts and the loop branch
  // pointer or index
  wire [15:0] jp_target = (I_OP_PREFIX == PFX_IDX1) ? ix :
                          (I_OP_PREFIX == PFX_IDX2) ? iy : hl;
  wire [15:0] rst_vec = {10'h000, rsel, 3'h0};
  wire [7:0] b_dec = regs[R_B] - 8'h01;
  wire [15:0] rel_target = I_OP_PC_NEXT + {{8{I_OP_IMM[7]}}, I_OP_IMM[7:0]};
  wire [15:0] hl_step = blk_down ? hl - 16'h0001 : hl + 16'h0001;

  ////////////////////////////////////////////////////////////////////////
  // Block transfer handshakes and BUF_DEPTH-entry buffer controls
  wire in_blk = (state == S_BLK);
  wire rd_ack = rd_busy & (blk_out ? I_MEM_ACK : I_IO_ACK);
  wire wr_ack = wr_busy & (blk_out ? I_IO_ACK : I_MEM_ACK);
  wire mem_ack_blk = blk_out ? rd_ack : wr_ack;
  wire buf_in_ready = (cnt < CW'(BUF_DEPTH));
  wire buf_out_valid = (cnt != '0);
  wire push = in_blk & rd_ack;
  wire pop = in_blk & wr_ack;
  wire [7:0] push_data = blk_out ? I_MEM_RDATA : I_IO_RDATA;
  // Back-pressure: no new read while the buffer is full
  wire issue_rd = in_blk & (rd_left != '0) & ~rd_busy & buf_in_ready;
  wire issue_wr = in_blk & buf_out_valid & ~wr_busy;
  wire blk_end = in_blk & (rd_left == '0) & ~rd_busy & ~wr_busy &
                 ~buf_out_valid;

  // Buffer storage and pointers
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        buf_mem[wp] <= push_data;
        wp <= (wp == PW'(BUF_DEPTH - 1)) ? '0 : wp + 1'b1;
      end
      if (pop)
        rp <= (rp == PW'(BUF_DEPTH - 1)) ? '0 : rp + 1'b1;
      cnt <= cnt + CW'(push) - CW'(pop);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution sequencer
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= S_IDLE;
      for (int k = 0; k < NUM_REGS; k++)
        regs[k] <= 8'h00;
      sp <= SP_RESET;
      ix <= '0;
      iy <= '0;
      pc <= PC_RESET;
      tgt <= '0;
      lat_next <= '0;
      io_dst <= '0;
      blk_out <= 1'b0;
      blk_down <= 1'b0;
      rd_busy <= 1'b0;
      wr_busy <= 1'b0;
      rd_left <= '0;
      O_OP_READY <= 1'b0;
      O_DONE <= 1'b0;
      O_RETURN_FROM_MASKABLE_IRQ <= 1'b0;
      O_MEM_REQ <= 1'b0;
      O_MEM_WR <= 1'b0;
      O_MEM_ADDR <= '0;
      O_MEM_WDATA <= '0;
      O_IO_REQ <= 1'b0;
      O_IO_WR <= 1'b0;
      O_IO_ADDR <= '0;
      O_IO_WDATA <= '0;
    end else begin
      O_DONE <= 1'b0;
      O_RETURN_FROM_MASKABLE_IRQ <= take & is_return_from_maskable_irq;
      unique case (state)
        S_IDLE: begin
          O_OP_READY <= 1'b1;
          if (take) begin
            lat_next <= I_OP_PC_NEXT;
            if (is_jp) begin
              pc <= jp_target;
              O_DONE <= 1'b1;
            end else if (is_loop) begin
              regs[R_B] <= b_dec;
              pc <= (b_dec != 8'h00) ? rel_target : I_OP_PC_NEXT;
              O_DONE <= 1'b1;
            end else if (is_call | is_rst) begin
              tgt <= is_rst ? rst_vec : I_OP_IMM;
              sp <= sp - 16'h0001;
              O_MEM_ADDR <= sp - 16'h0001;
              O_MEM_WDATA <= I_OP_PC_NEXT[15:8];
              O_MEM_REQ <= 1'b1;
              O_MEM_WR <= 1'b1;
              O_OP_READY <= 1'b0;
              state <= S_PUSH_HI;
            end else if (is_ret) begin
              O_MEM_ADDR <= sp;
              O_MEM_REQ <= 1'b1;
              O_MEM_WR <= 1'b0;
              O_OP_READY <= 1'b0;
              state <= S_POP_LO;
            end else if (is_in_imm | is_out_imm) begin
              O_IO_ADDR <= {regs[R_A], I_OP_IMM[7:0]};
              O_IO_WDATA <= regs[R_A];
              O_IO_WR <= is_out_imm;
              O_IO_REQ <= 1'b1;
              io_dst <= R_A;
              O_OP_READY <= 1'b0;
              state <= S_IO;
            end else if (is_in_reg | is_out_reg) begin
              O_IO_ADDR <= bc;
              O_IO_WDATA <= regs[rsel];
              O_IO_WR <= is_out_reg;
              O_IO_REQ <= 1'b1;
              io_dst <= rsel;
              O_OP_READY <= 1'b0;
              state <= S_IO;
            end else if (is_blk) begin
              // count from B when repeating, zero means 256; otherwise one byte
              blk_out <= I_OP_CODE[BLK_OUT_BIT];
              blk_down <= I_OP_CODE[BLK_DOWN_BIT];
              rd_left <= ~I_OP_CODE[BLK_RPT_BIT] ? BLK_ONE :
                         (regs[R_B] == 8'h00) ? BLK_FULL : {1'b0, regs[R_B]};
              O_OP_READY <= 1'b0;
              state <= S_BLK;
            end else begin
              pc <= I_OP_PC_NEXT;
              O_DONE <= 1'b1;
            end
          end else if (I_REG_WE) begin
            if (I_REG_SEL == LD_SP)
              sp <= I_REG_DATA;
            else if (I_REG_SEL == LD_IX)
              ix <= I_REG_DATA;
            else if (I_REG_SEL == LD_IY)
              iy <= I_REG_DATA;
            else if (!I_REG_SEL[3])
              regs[I_REG_SEL[2:0]] <= I_REG_DATA[7:0];
          end
        end
        S_PUSH_HI: if (I_MEM_ACK) begin
          sp <= sp - 16'h0001;
          O_MEM_ADDR <= sp - 16'h0001;
          O_MEM_WDATA <= lat_next[7:0];
          state <= S_PUSH_LO;
        end
        S_PUSH_LO: if (I_MEM_ACK) begin
          O_MEM_REQ <= 1'b0;
          O_MEM_WR <= 1'b0;
          pc <= tgt;
          O_DONE <= 1'b1;
          O_OP_READY <= 1'b1;
          state <= S_IDLE;
        end
        S_POP_LO: if (I_MEM_ACK) begin
          tgt[7:0] <= I_MEM_RDATA;
          sp <= sp + 16'h0001;
          O_MEM_ADDR <= sp + 16'h0001;
          state <= S_POP_HI;
        end
        S_POP_HI: if (I_MEM_ACK) begin
          O_MEM_REQ <= 1'b0;
          pc <= {I_MEM_RDATA, tgt[7:0]};
          sp <= sp + 16'h0001;
          O_DONE <= 1'b1;
          O_OP_READY <= 1'b1;
          state <= S_IDLE;
        end
        S_IO: if (I_IO_ACK) begin
          O_IO_REQ <= 1'b0;
          O_IO_WR <= 1'b0;
          if (!O_IO_WR)
            regs[io_dst] <= I_IO_RDATA;
          pc <= lat_next;
          O_DONE <= 1'b1;
          O_OP_READY <= 1'b1;
          state <= S_IDLE;
        end
        S_BLK: begin
          if (rd_ack) begin
            rd_busy <= 1'b0;
            rd_left <= rd_left - BLK_ONE;
            regs[R_B] <= b_dec;
            if (blk_out)
              O_MEM_REQ <= 1'b0;
            else
              O_IO_REQ <= 1'b0;
          end
          if (wr_ack) begin
            wr_busy <= 1'b0;
            if (blk_out)
              O_IO_REQ <= 1'b0;
            else
              O_MEM_REQ <= 1'b0;
          end
          // pointer steps on each memory byte
          if (mem_ack_blk)
            {regs[R_H], regs[R_L]} <= hl_step;
          if (issue_rd) begin
            rd_busy <= 1'b1;
            if (blk_out) begin
              O_MEM_REQ <= 1'b1;
              O_MEM_WR <= 1'b0;
              O_MEM_ADDR <= hl;
            end else begin
              O_IO_REQ <= 1'b1;
              O_IO_WR <= 1'b0;
              O_IO_ADDR <= bc;
            end
          end
          if (issue_wr) begin
            wr_busy <= 1'b1;
            if (blk_out) begin
              O_IO_REQ <= 1'b1;
              O_IO_WR <= 1'b1;
              O_IO_ADDR <= bc;
              O_IO_WDATA <= buf_mem[rp];
            end else begin
              O_MEM_REQ <= 1'b1;
              O_MEM_WR <= 1'b1;
              O_MEM_ADDR <= hl;
              O_MEM_WDATA <= buf_mem[rp];
            end
          end
          if (blk_end) begin
            pc <= lat_next;
            O_DONE <= 1'b1;
            O_OP_READY <= 1'b1;
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Architectural state views
  assign O_PC = pc;
  assign O_SP = sp;
  assign O_B = regs[R_B];
  assign O_HL = hl;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  a_ind_jump_pc: assert property (take && is_jp |=> O_PC == $past(jp_target))
    else $error("indirect jump target wrong");
  a_call_push_hi: assert property (take && is_call |=> O_MEM_REQ && O_MEM_WR
    && O_MEM_WDATA == $past(I_OP_PC_NEXT[15:8])
    && O_MEM_ADDR == $past(sp) - 16'h0001)
    else $error("call does not push high byte first");
  a_push_then_load: assert property (state == S_PUSH_LO && I_MEM_ACK
    |=> O_PC == $past(tgt) && O_DONE && O_SP == $past(sp))
    else $error("push ending wrong");
  a_ret_pop_read: assert property (take && is_ret |=> O_MEM_REQ && !O_MEM_WR
    && O_MEM_ADDR == $past(sp) ##0 state == S_POP_LO)
    else $error("return does not pop");
  a_ret_pc_load: assert property (state == S_POP_HI && I_MEM_ACK
    |=> O_PC == {$past(I_MEM_RDATA), $past(tgt[7:0])})
    else $error("return address wrong");
  a_return_from_maskable_irq_marker: assert property (take && is_return_from_maskable_irq |=> O_RETURN_FROM_MASKABLE_IRQ ##1 !O_RETURN_FROM_MASKABLE_IRQ)
    else $error("interrupt return marker missing");
  a_loop_branch: assert property (take && is_loop |=> O_B == $past(b_dec)
    && O_PC == ($past(b_dec) != 8'h00 ? $past(rel_target)
    : $past(I_OP_PC_NEXT)))
    else $error("count-down branch wrong");
  a_rst_vector: assert property (take && is_rst |=> tgt == {10'h000,
    $past(I_OP_CODE[RSEL_MSB:RSEL_LSB]), 3'h0})
    else $error("restart vector wrong");
  a_imm_port_addr: assert property (take && (is_in_imm || is_out_imm)
    |=> O_IO_REQ && O_IO_ADDR == {$past(regs[R_A]), $past(I_OP_IMM[7:0])})
    else $error("immediate port address wrong");
  a_ind_port_addr: assert property (take && (is_in_reg || is_out_reg)
    |=> O_IO_REQ && O_IO_ADDR == $past(bc)
    && O_IO_WDATA == $past(regs[rsel]))
    else $error("indirect port access wrong");
  a_blk_step: assert property (push |=> O_B == $past(b_dec))
    else $error("block count not decremented");
  a_blk_pointer: assert property (in_blk && mem_ack_blk
    |=> O_HL == $past(hl_step))
    else $error("block pointer not stepped");
  a_blk_port_addr: assert property (in_blk && issue_rd && !blk_out
    |=> O_IO_ADDR == $past(bc))
    else $error("block port address wrong");
  a_buf_bound: assert property (cnt <= CW'(BUF_DEPTH))
    else $error("buffer overfilled");

  c_call_done: cover property (state == S_PUSH_LO && I_MEM_ACK);
  c_return_from_maskable_irq_seen: cover property (O_RETURN_FROM_MASKABLE_IRQ);
  c_blk_full: cover property (in_blk && !buf_in_ready);
  c_blk_end: cover property (blk_end);
endmodule : jcp_exec
`default_nettype wire

/* File: bench/jcp_io_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// Memory and port peripheral model on the far side of the block
module jcp_io_peer (
  input wire logic i_clk,
  input wire logic [3:0] i_mem_delay,
  input wire logic [3:0] i_io_delay,
  input wire logic i_mem_req,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_mem_ack = 1'b0,
  output logic [7:0] o_mem_rdata = 8'h00,
  input wire logic i_io_req,
  input wire logic i_io_wr,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  output logic o_io_ack = 1'b0,
  output logic [7:0] o_io_rdata = 8'h00,
  input wire logic i_return_from_maskable_irq
);
  logic [7:0] mem [0:65535];
  logic [15:0] io_addr_q[$];
  logic [7:0] io_data_q[$];
  int return_from_maskable_irq_cnt = 0;
  logic [3:0] mem_wait = 4'h0;
  logic [3:0] io_wait = 4'h0;
  ////////////////////////////////////////////////////////////////////////
  // Memory side: one-cycle ack after the chosen wait, data toggles idle
  always @(posedge i_clk) begin
    if (o_mem_ack) begin
      o_mem_ack <= 1'b0;
      mem_wait <= 4'h0;
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_wr) mem[i_mem_addr] <= i_mem_wdata;
    end else if (i_mem_req && mem_wait >= i_mem_delay) begin
      o_mem_ack <= 1'b1;
      o_mem_rdata <= mem[i_mem_addr];
    end else begin
      mem_wait <= i_mem_req ? mem_wait + 4'h1 : 4'h0;
      o_mem_rdata <= ~o_mem_rdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Port side: read data derived from the upper address byte, all logged
  always @(posedge i_clk) begin
    if (o_io_ack) begin
      o_io_ack <= 1'b0;
      io_wait <= 4'h0;
      o_io_rdata <= ~o_io_rdata;
      io_addr_q.push_back(i_io_addr);
      io_data_q.push_back(i_io_wr ? i_io_wdata : o_io_rdata);
    end else if (i_io_req && io_wait >= i_io_delay) begin
      o_io_ack <= 1'b1;
      o_io_rdata <= i_io_addr[15:8] ^ 8'h5a;
    end else begin
      io_wait <= i_io_req ? io_wait + 4'h1 : 4'h0;
      o_io_rdata <= ~o_io_rdata;
    end
  end
  always @(posedge i_clk) begin
    if (i_return_from_maskable_irq) return_from_maskable_irq_cnt <= return_from_maskable_irq_cnt + 1;
  end
endmodule : jcp_io_peer
`default_nettype wire

/* File: bench/jcp_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module jcp_exec_tb import jcp_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, reg_we = 1'b0;
  logic [7:0] op_pfx = 8'h00, op_code = 8'h00;
  logic [15:0] op_imm = 16'h0000, op_pcn = 16'h0000, reg_data = 16'h0000;
  logic [3:0] reg_sel = 4'h0, mem_dly = 4'h0, io_dly = 4'h0;
  logic ready, done, return_from_maskable_irq, mem_req, mem_wr, mem_ack, io_req, io_wr, io_ack;
  logic [15:0] pc, sp, hl, mem_addr, io_addr;
  logic [7:0] b, mem_wdata, mem_rdata, io_wdata, io_rdata;
  int n_fail = 0;
  int cmp_count = 0;
  localparam logic [15:0] RETS [3] = '{{PFX_NONE, OP_RET},
    {PFX_EXT, OP_RET_NMI}, {PFX_EXT, OP_RET_MI}};
  localparam logic [7:0] VALS [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a,
    8'hbc, 8'h00, 8'hde};

  jcp_exec uut (.I_REF_CLK(clk), .I_RESET(rst), .I_OP_VALID(op_valid),
    .I_OP_PREFIX(op_pfx), .I_OP_CODE(op_code), .I_OP_IMM(op_imm),
    .I_OP_PC_NEXT(op_pcn), .O_OP_READY(ready), .O_DONE(done), .O_RETURN_FROM_MASKABLE_IRQ(return_from_maskable_irq),
    .I_REG_WE(reg_we), .I_REG_SEL(reg_sel), .I_REG_DATA(reg_data), .O_PC(pc),
    .O_SP(sp), .O_B(b), .O_HL(hl), .O_MEM_REQ(mem_req), .O_MEM_WR(mem_wr),
    .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .I_MEM_ACK(mem_ack),
    .I_MEM_RDATA(mem_rdata), .O_IO_REQ(io_req), .O_IO_WR(io_wr),
    .O_IO_ADDR(io_addr), .O_IO_WDATA(io_wdata), .I_IO_ACK(io_ack),
    .I_IO_RDATA(io_rdata));
  jcp_io_peer peer (.i_clk(clk), .i_mem_delay(mem_dly), .i_io_delay(io_dly),
    .i_mem_req(mem_req), .i_mem_wr(mem_wr), .i_mem_addr(mem_addr),
    .i_mem_wdata(mem_wdata), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata),
    .i_io_req(io_req), .i_io_wr(io_wr), .i_io_addr(io_addr),
    .i_io_wdata(io_wdata), .o_io_ack(io_ack), .o_io_rdata(io_rdata),
    .i_return_from_maskable_irq(return_from_maskable_irq));

  // Free-running clock
  always #20 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
        exp);
    end
  endtask : chk
  // Next logged port cycle against address and data
  task automatic io_exp(input logic [15:0] a, input logic [7:0] d);
    if (peer.io_addr_q.size() == 0) begin
      chk(16'h0000, 16'h0001, "missing port cycle");
    end else begin
      chk(peer.io_addr_q.pop_front(), a, "port address");
      chk({8'h00, peer.io_data_q.pop_front()}, {8'h00, d}, "port data");
    end
  endtask : io_exp
  task automatic load(input logic [3:0] sel, input logic [15:0] val);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_sel <= sel;
    reg_data <= val;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : load
  task automatic run(input logic [7:0] pfx, input logic [7:0] code,
      input logic [15:0] imm, input logic [15:0] pcn);
    int n;
    @(posedge clk);
    op_valid <= 1'b1;
    op_pfx <= pfx;
    op_code <= code;
    op_imm <= imm;
    op_pcn <= pcn;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ready !== 1'b1 && n < 100);
    @(posedge clk);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (n >= 3000) chk(16'h0000, 16'h0001, "no completion");
  endtask : run
  ////////////////////////////////////////////////////////////////////////
  task automatic t_jump();
    load({1'b0, R_H}, 16'h0012);
    load({1'b0, R_L}, 16'h0034);
    load(LD_IX, 16'ha5c3);
    load(LD_IY, 16'h5a3c);
    run(PFX_NONE, OP_JP_IND, 16'h0000, 16'h0001);
    chk(pc, 16'h1234, "jump pair");
    run(PFX_IDX1, OP_JP_IND, 16'h0000, 16'h0001);
    chk(pc, 16'ha5c3, "jump index one");
    run(PFX_IDX2, OP_JP_IND, 16'h0000, 16'h0001);
    chk(pc, 16'h5a3c, "jump index two");
  endtask : t_jump
  task automatic t_call_ret();
    mem_dly <= 4'h2;
    load(LD_SP, 16'h1000);
    run(PFX_NONE, OP_CALL, 16'h3456, 16'h0203);
    chk(pc, 16'h3456, "call target");
    chk(sp, 16'h0ffe, "call stack");
    chk({peer.mem[16'h0fff], peer.mem[16'h0ffe]}, 16'h0203, "pushed");
    for (int i = 0; i < 3; i++) begin
      peer.mem[16'h0ffe] = 8'h10 + 8'(i);
      peer.mem[16'h0fff] = 8'h70;
      run(RETS[i][15:8], RETS[i][7:0], 16'h0000, 16'h0001);
      chk(pc, 16'h7010 + 16'(i), "popped");
      chk(sp, 16'h1000, "pop stack");
      load(LD_SP, 16'h0ffe);
    end
    chk(16'(peer.return_from_maskable_irq_cnt), 16'h0001, "return notice");
    mem_dly <= 4'h0;
  endtask : t_call_ret
  task automatic t_restart();
    for (int k = 0; k < 8; k++) begin
      load(LD_SP, 16'h2000);
      run(PFX_NONE, RST_MATCH | 8'(k << 3), 16'h0000, 16'h4000 + 16'(k));
      chk(pc, 16'(k * 8), "vector");
      chk({peer.mem[16'h1fff], peer.mem[16'h1ffe]}, 16'h4000 + 16'(k),
        "vector push");
    end
  endtask : t_restart
  task automatic t_loop();
    load({1'b0, R_B}, 16'h0002);
    run(PFX_NONE, OP_LOOP, 16'h00f8, 16'h0100);
    chk({8'h00, b}, 16'h0001, "count branch b");
    chk(pc, 16'h00f8, "count branch pc");
    run(PFX_NONE, OP_LOOP, 16'h00f8, 16'h0100);
    chk({8'h00, b}, 16'h0000, "count fall b");
    chk(pc, 16'h0100, "count fall pc");
    run(PFX_NONE, OP_LOOP, 16'h007f, 16'h0100);
    chk({8'h00, b}, 16'h00ff, "count wrap b");
    chk(pc, 16'h017f, "count wrap pc");
  endtask : t_loop
  task automatic t_port();
    io_dly <= 4'h1;
    load({1'b0, R_A}, 16'h009a);
    run(PFX_NONE, OP_OUT_IMM, 16'h0034, 16'h0001);
    io_exp(16'h9a34, 8'h9a);
    run(PFX_NONE, OP_IN_IMM, 16'h0021, 16'h0001);
    io_exp(16'h9a21, 8'hc0);
    run(PFX_NONE, OP_OUT_IMM, 16'h0077, 16'h0001);
    io_exp(16'hc077, 8'hc0);
    for (int r = 0; r < 8; r++) load(4'(r), {8'h00, VALS[r]});
    for (int r = 0; r < 8; r++) begin
      if (r == 6) continue;
      run(PFX_EXT, OUT_REG_MATCH | 8'(r << 3), 16'h0000, 16'h0001);
      io_exp(16'h1234, VALS[r]);
    end
    run(PFX_EXT, IN_REG_MATCH | 8'h18, 16'h0000, 16'h0001);
    io_exp(16'h1234, 8'h48);
    run(PFX_EXT, IN_REG_MATCH | 8'h28, 16'h0000, 16'h0001);
    io_exp(16'h1234, 8'h48);
    chk(hl, 16'h9a48, "read into pair low");
    run(PFX_EXT, OUT_REG_MATCH | 8'h18, 16'h0000, 16'h0001);
    io_exp(16'h1234, 8'h48);
  endtask : t_port
  task automatic t_block();
    logic [15:0] a;
    int n;
    for (int v = 0; v < 8; v++) begin
      n = v[1] ? 3 : 1;
      mem_dly <= v[2] ? 4'h0 : 4'h3;
      io_dly <= v[2] ? 4'h3 : 4'h0;
      for (int j = 0; j < 3; j++) begin
        a = v[0] ? 16'h3000 - 16'(j) : 16'h3000 + 16'(j);
        peer.mem[a] = 8'ha0 + 8'(j);
      end
      load({1'b0, R_B}, 16'h0003);
      load({1'b0, R_C}, 16'h0055);
      load({1'b0, R_H}, 16'h0030);
      load({1'b0, R_L}, 16'h0000);
      run(PFX_EXT, BLK_MATCH | (v[1] ? 8'h10 : 8'h00) |
        (v[0] ? 8'h08 : 8'h00) | (v[2] ? 8'h01 : 8'h00),
        16'h0000, 16'h0001);
      for (int j = 0; j < n; j++) begin
        a = v[0] ? 16'h3000 - 16'(j) : 16'h3000 + 16'(j);
        if (v[2]) begin
          // Count drops on the memory read, before the port write issues
          io_exp({8'(2 - j), 8'h55}, 8'ha0 + 8'(j));
        end else begin
          io_exp({8'(3 - j), 8'h55}, 8'(3 - j) ^ 8'h5a);
          chk({8'h00, peer.mem[a]}, {8'h00, 8'(3 - j) ^ 8'h5a}, "stored");
        end
      end
      chk(hl, v[0] ? 16'h3000 - 16'(n) : 16'h3000 + 16'(n), "ptr");
      chk({8'h00, b}, 16'(3 - n), "count");
    end
    load({1'b0, R_B}, 16'h0000);
    run(PFX_EXT, BLK_MATCH | 8'h10, 16'h0000, 16'h0001);
    chk(16'(peer.io_addr_q.size()), 16'h0100, "full block");
    // Pointer starts where the last down transfer left it
    chk(hl, 16'h30fd, "full block ptr");
    chk({8'h00, b}, 16'h0000, "full block count");
    peer.io_addr_q.delete();
    peer.io_data_q.delete();
  endtask : t_block
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_jump();
    t_call_ret();
    t_restart();
    t_loop();
    t_port();
    t_block();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #(40 * 50000);
    n_fail++;
    final_report();
  end
endmodule : jcp_exec_tb
`default_nettype wire
